// ===== stx_map.svh
`ifndef STX_MAP_SVH
`define STX_MAP_SVH
// Overview of operation
// - an empty shifter takes the holding byte and starts sending it
// - a byte waiting during a frame is loaded at its end, with no gap
// - reset fills the transmit holding register with all ones
// - format bit 7 picks asynchronous (0) or clocked synchronous (1) mode, resets 0
// - asynchronous format bit 6 picks eight (0) or seven (1) data bits
// - length, parity and stop settings are ignored in clocked synchronous mode
// - parity on adds a parity bit when sending and checks it when receiving
// - format bit 4 picks even (0) or odd (1) parity when parity is on
// - format bit 3 sends one (0) or two (1) stop bits
// - the receiver checks only the first stop bit for framing
// - a low bit after the first stop bit starts the next character
// - format bit 2 enables multiprocessor framing and overrides both parity settings
// - format bits 1:0 pick clock, clock/4, clock/16 or clock/64 for the bit-rate divider
// - each character leaves least significant bit first

// register offsets
`define STX_OFS_HOLD     3'h0
`define STX_OFS_FMT      3'h1
`define STX_OFS_STAT     3'h2
`define STX_OFS_DIV      3'h3
`define STX_OFS_CTRL     3'h4
`define STX_OFS_RXDATA   3'h5
// status bits
`define STX_ST_EMPTY     7
`define STX_ST_RXFULL    6
`define STX_ST_FERR      4
`define STX_ST_PERR      3
`define STX_ST_TXEND     2
// control bits
`define STX_CT_TXEN      5
`define STX_CT_RXEN      4
`define STX_CT_MPBIT     0
`define STX_CT_MASK      8'h31
// reset values
`define STX_RST_HOLD     8'hff
`define STX_RST_FMT      8'h00
`define STX_RST_DIV      8'hff
`define STX_RST_CTRL     8'h00
// bit timing in sample ticks, and the synchronous frame length in bits
`define STX_TICK_LAST    4'hf
`define STX_TICK_HALF    4'h7
`define STX_SYNC_LEN     4'h8
// prescaler terminal counts for select codes 00 to 11
`define STX_PRE_LIM0     6'h00
`define STX_PRE_LIM1     6'h03
`define STX_PRE_LIM2     6'h0f
`define STX_PRE_LIM3     6'h3f
`endif

// ===== stx_pkg.sv
package stx_pkg;
  typedef struct packed {
    logic       sync;
    logic       chr;
    logic       pe;
    logic       pm;
    logic       stop2;
    logic       mp;
    logic [1:0] cks;
  } stx_fmt_s;

  typedef struct packed {
    logic       done;
    logic       perr;
    logic       ferr;
    logic [7:0] data;
  } stx_rx_res_s;

  typedef enum logic [2:0] {
    RX_IDLE  = 3'b000,
    RX_START = 3'b001,
    RX_DATA  = 3'b010,
    RX_EXT   = 3'b011,
    RX_STOP  = 3'b100
  } stx_rx_st_e;
endpackage : stx_pkg

// ===== stx_baud.sv
`timescale 1ns/1ps
`include "stx_map.svh"
module stx_baud (
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic [1:0] cks,
  input  wire logic [7:0] divisor,
  output logic            tick
);
  typedef struct packed {
    logic [5:0] pre;
    logic [7:0] div;
    logic       tick;
  } stx_baud_s;
  stx_baud_s s;
  stx_baud_s n;
  logic [5:0] lim;

  always_comb begin
    case (cks)
      2'b00:   lim = `STX_PRE_LIM0;
      2'b01:   lim = `STX_PRE_LIM1;
      2'b10:   lim = `STX_PRE_LIM2;
      default: lim = `STX_PRE_LIM3;
    endcase
    n = s;
    n.tick = 1'b0;
    if (s.pre >= lim) begin
      n.pre = 6'h00;
      if (s.div >= divisor) begin
        n.div  = 8'h00;
        n.tick = 1'b1;
      end else begin
        n.div = s.div + 8'h01;
      end
    end else begin
      n.pre = s.pre + 6'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end
  assign tick = s.tick;
endmodule : stx_baud

// ===== stx_rx.sv
`timescale 1ns/1ps
`include "stx_map.svh"
module stx_rx (
  input  wire logic                clk,
  input  wire logic                rst_b,
  input  wire logic                tick,
  input  wire logic                rxd,
  input  wire logic                enable,
  input  stx_pkg::stx_fmt_s        fmt,
  output stx_pkg::stx_rx_res_s     res
);
  typedef struct packed {
    stx_pkg::stx_rx_st_e  st;
    logic [3:0]           cnt;
    logic [2:0]           bitn;
    logic [7:0]           sh;
    logic                 ext;
    stx_pkg::stx_rx_res_s res;
  } stx_rxs_s;
  stx_rxs_s s;
  stx_rxs_s n;
  logic     has_ext;
  logic     last_tick;

  assign has_ext   = fmt.pe | fmt.mp;
  assign last_tick = tick && s.cnt == `STX_TICK_LAST;

  always_comb begin
    n = s;
    n.res.done = 1'b0;
    if (tick) begin
      n.cnt = s.cnt + 4'h1;
    end
    case (s.st)
      stx_pkg::RX_IDLE: begin
        if (enable && !rxd) begin
          n.st  = stx_pkg::RX_START;
          n.cnt = 4'h0;
        end
      end
      stx_pkg::RX_START: begin
        if (tick && s.cnt == `STX_TICK_HALF) begin
          n.cnt  = 4'h0;
          n.bitn = 3'h0;
          n.st   = rxd ? stx_pkg::RX_IDLE : stx_pkg::RX_DATA;
        end
      end
      stx_pkg::RX_DATA: begin
        if (last_tick) begin
          n.sh   = {rxd, s.sh[7:1]};
          n.bitn = s.bitn + 3'h1;
          if (s.bitn == (fmt.chr ? 3'h6 : 3'h7)) begin
            n.st = has_ext ? stx_pkg::RX_EXT : stx_pkg::RX_STOP;
          end
        end
      end
      stx_pkg::RX_EXT: begin
        if (last_tick) begin
          n.ext = rxd;
          n.st  = stx_pkg::RX_STOP;
        end
      end
      stx_pkg::RX_STOP: begin
        if (last_tick) begin
          n.st       = stx_pkg::RX_IDLE;
          n.res.done = 1'b1;
          n.res.ferr = !rxd;
          n.res.data = fmt.chr ? {1'b0, s.sh[7:1]} : s.sh;
          // multiprocessor framing carries no parity
          n.res.perr = fmt.pe && !fmt.mp &&
                       (s.ext != ((fmt.chr ? ^s.sh[7:1] : ^s.sh) ^ fmt.pm));
        end
      end
      default: n.st = stx_pkg::RX_IDLE;
    endcase
    if (!enable || fmt.sync) begin
      n.st = stx_pkg::RX_IDLE;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end
  assign res = s.res;

  property p_one_stop;
    @(posedge clk) disable iff (!rst_b)
    (s.st == stx_pkg::RX_STOP && last_tick && enable && !fmt.sync)
      |=> (s.st == stx_pkg::RX_IDLE && res.done);
  endproperty
  a_one_stop: assert property (p_one_stop) else $error("receiver did not end on first stop");
endmodule : stx_rx

// ===== stx_top.sv
`timescale 1ns/1ps
`include "stx_map.svh"
module stx_top (
  input  wire logic       SYS_CLK,
  input  wire logic       RST_B,
  input  wire logic [2:0] REG_ADDR,
  input  wire logic [7:0] REG_WDATA,
  input  wire logic       REG_WR,
  input  wire logic       REG_RD,
  output logic      [7:0] REG_RDATA,
  input  wire logic       RXD,
  output logic            TXD,
  output logic            SCK_OUT,
  output logic            TX_EMPTY
);
  typedef struct packed {
    logic [7:0]        hold;
    logic              full;
    stx_pkg::stx_fmt_s fmt;
    logic [7:0]        div;
    logic [7:0]        ctrl;
    logic [7:0]        rdata;
    logic [11:0]       sh;
    logic [3:0]        left;
    logic [3:0]        bcnt;
    logic              busy;
    logic              line;
    logic              sck;
    logic              txend;
    logic [7:0]        rx_data;
    logic              rx_full;
    logic              perr;
    logic              ferr;
    logic              rx_meta;
    logic              rx_sync;
  } stx_top_s;

  stx_top_s             s;
  stx_top_s             n;
  logic                 tick;
  stx_pkg::stx_rx_res_s rx_res;
  logic                 bit_end;
  logic                 frame_done;
  logic                 load;
  logic [11:0]          frame;
  logic [3:0]           frame_len;

  ////////////////////////////////////////////////////////////////////////////
  // frame builder: start, data lsb first, optional parity or mp bit, stops

  function automatic logic [15:0] build_frame(input logic [7:0] d,
                                              input stx_pkg::stx_fmt_s f,
                                              input logic mp_bit);
    logic [11:0] b;
    logic [3:0]  pos;
    logic [3:0]  len;
    logic        ext;
    b   = 12'hfff;
    pos = 4'h0;
    len = 4'h0;
    ext = 1'b0;
    if (f.sync) begin
      // synchronous characters are always eight bits, bare
      b   = {4'hf, d};
      len = `STX_SYNC_LEN;
    end else begin
      b[0] = 1'b0;
      for (int i = 0; i < 8; i++) begin
        if (i < 7 || !f.chr) begin
          b[i + 1] = d[i];
        end
      end
      pos = f.chr ? 4'h8 : 4'h9;
      if (f.mp) begin
        b[pos] = mp_bit;
        pos    = pos + 4'h1;
      end else if (f.pe) begin
        ext    = (f.chr ? ^d[6:0] : ^d) ^ f.pm;
        b[pos] = ext;
        pos    = pos + 4'h1;
      end
      len = pos + (f.stop2 ? 4'h2 : 4'h1);
    end
    return {len, b};
  endfunction : build_frame

  assign {frame_len, frame} = build_frame(s.hold, s.fmt, s.ctrl[`STX_CT_MPBIT]);

  ////////////////////////////////////////////////////////////////////////////
  // rate generation and receive path

  stx_baud u_baud (
    .clk     (SYS_CLK),
    .rst_b   (RST_B),
    .cks     (s.fmt.cks),
    .divisor (s.div),
    .tick    (tick)
  );

  stx_rx u_rx (
    .clk    (SYS_CLK),
    .rst_b  (RST_B),
    .tick   (tick),
    .rxd    (s.rx_sync),
    .enable (s.ctrl[`STX_CT_RXEN]),
    .fmt    (s.fmt),
    .res    (rx_res)
  );

  ////////////////////////////////////////////////////////////////////////////
  // next state

  assign bit_end    = s.busy && tick && s.bcnt == `STX_TICK_LAST;
  assign frame_done = bit_end && s.left == 4'h1;
  // a waiting byte follows the last bit in the very next bit slot
  assign load       = s.ctrl[`STX_CT_TXEN] && s.full && (!s.busy || frame_done);

  always_comb begin
    n = s;
    n.rx_meta = RXD;
    n.rx_sync = s.rx_meta;
    n.rdata   = 8'h00;

    // shifter
    if (s.busy && tick) begin
      n.bcnt = s.bcnt + 4'h1;
    end
    if (bit_end) begin
      n.sh   = {1'b1, s.sh[11:1]};
      n.left = s.left - 4'h1;
      if (frame_done) begin
        n.busy  = 1'b0;
        n.txend = 1'b1;
      end
    end
    if (load) begin
      n.sh    = frame;
      n.left  = frame_len;
      n.bcnt  = 4'h0;
      n.busy  = 1'b1;
      n.full  = 1'b0;
      n.txend = 1'b0;
    end

    // register reads
    if (REG_RD) begin
      if (REG_ADDR == `STX_OFS_HOLD) begin
        n.rdata = s.hold;
      end else if (REG_ADDR == `STX_OFS_FMT) begin
        n.rdata = s.fmt;
      end else if (REG_ADDR == `STX_OFS_STAT) begin
        n.rdata[`STX_ST_EMPTY]  = !s.full;
        n.rdata[`STX_ST_RXFULL] = s.rx_full;
        n.rdata[`STX_ST_FERR]   = s.ferr;
        n.rdata[`STX_ST_PERR]   = s.perr;
        n.rdata[`STX_ST_TXEND]  = s.txend;
      end else if (REG_ADDR == `STX_OFS_DIV) begin
        n.rdata = s.div;
      end else if (REG_ADDR == `STX_OFS_CTRL) begin
        n.rdata = s.ctrl;
      end else if (REG_ADDR == `STX_OFS_RXDATA) begin
        n.rdata   = s.rx_data;
        n.rx_full = 1'b0;
      end else begin
        n.rdata = 8'h00;
      end
    end

    // register writes; a write to the holding register in a load cycle
    // refills it, since the load has already taken the old byte
    if (REG_WR) begin
      if (REG_ADDR == `STX_OFS_HOLD) begin
        n.hold = REG_WDATA;
        n.full = 1'b1;
      end else if (REG_ADDR == `STX_OFS_FMT) begin
        n.fmt = REG_WDATA;
      end else if (REG_ADDR == `STX_OFS_STAT) begin
        if (REG_WDATA[`STX_ST_RXFULL]) begin
          n.rx_full = 1'b0;
        end
        if (REG_WDATA[`STX_ST_FERR]) begin
          n.ferr = 1'b0;
        end
        if (REG_WDATA[`STX_ST_PERR]) begin
          n.perr = 1'b0;
        end
      end else if (REG_ADDR == `STX_OFS_DIV) begin
        n.div = REG_WDATA;
      end else if (REG_ADDR == `STX_OFS_CTRL) begin
        n.ctrl = REG_WDATA & `STX_CT_MASK;
      end
    end

    // receive results win over a clear in the same cycle
    if (rx_res.done) begin
      n.rx_data = rx_res.data;
      n.rx_full = 1'b1;
      if (rx_res.perr) begin
        n.perr = 1'b1;
      end
      if (rx_res.ferr) begin
        n.ferr = 1'b1;
      end
    end

    n.line = n.busy ? n.sh[0] : 1'b1;
    // clock idles high; data changes on the falling half
    n.sck  = !(n.busy && s.fmt.sync) || n.bcnt[3];
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RST_B) begin
      s       <= '0;
      s.hold  <= `STX_RST_HOLD;
      s.fmt   <= `STX_RST_FMT;
      s.div   <= `STX_RST_DIV;
      s.ctrl  <= `STX_RST_CTRL;
      s.line  <= 1'b1;
      s.sck   <= 1'b1;
      s.txend <= 1'b1;
      // idle line level, so a later enable sees no false start
      s.rx_meta <= 1'b1;
      s.rx_sync <= 1'b1;
    end else begin
      s <= n;
    end
  end

  assign REG_RDATA = s.rdata;
  assign TXD       = s.line;
  assign SCK_OUT   = s.sck;
  assign TX_EMPTY  = !s.full;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  sequence s_frame_end;
    s.busy && tick && s.bcnt == `STX_TICK_LAST && s.left == 4'h1;
  endsequence

  sequence s_next_start;
    s.busy && s.left != 4'h0 ##0 (s.fmt.sync || !TXD);
  endsequence

  property p_load_idle;
    @(posedge SYS_CLK) disable iff (!RST_B)
    (s.ctrl[`STX_CT_TXEN] && s.full && !s.busy && !REG_WR)
      |=> (s.busy && !s.full && TX_EMPTY);
  endproperty
  a_load_idle: assert property (p_load_idle) else $error("idle shifter did not take byte");

  property p_no_gap;
    @(posedge SYS_CLK) disable iff (!RST_B)
    (s_frame_end ##0 (s.full && s.ctrl[`STX_CT_TXEN])) |=> s_next_start;
  endproperty
  a_no_gap: assert property (p_no_gap) else $error("gap between back to back frames");

  property p_reset_hold;
    @(posedge SYS_CLK)
    !RST_B |=> (s.hold == 8'hff && s.fmt.sync == 1'b0);
  endproperty
  a_reset_hold: assert property (p_reset_hold) else $error("holding register not all ones");

  property p_sync_len;
    @(posedge SYS_CLK) disable iff (!RST_B)
    (load && s.fmt.sync) |=> (s.left == 4'h8 && s.sh[7:0] == $past(s.hold));
  endproperty
  a_sync_len: assert property (p_sync_len) else $error("sync frame not eight bare bits");

  property p_async_len;
    @(posedge SYS_CLK) disable iff (!RST_B)
    (load && !s.fmt.sync)
      |=> (s.left == ($past(s.fmt.chr) ? 4'h9 : 4'ha)
                     + (($past(s.fmt.pe) || $past(s.fmt.mp)) ? 4'h1 : 4'h0)
                     + ($past(s.fmt.stop2) ? 4'h1 : 4'h0));
  endproperty
  a_async_len: assert property (p_async_len) else $error("async frame length wrong");

  property p_parity;
    @(posedge SYS_CLK) disable iff (!RST_B)
    (load && !s.fmt.sync && s.fmt.pe && !s.fmt.mp && !s.fmt.chr)
      |=> (s.sh[9] == (^s.sh[8:1] ^ $past(s.fmt.pm)));
  endproperty
  a_parity: assert property (p_parity) else $error("parity bit wrong");

  property p_mp_bit;
    @(posedge SYS_CLK) disable iff (!RST_B)
    (load && !s.fmt.sync && s.fmt.mp && !s.fmt.chr)
      |=> (s.sh[9] == $past(s.ctrl[`STX_CT_MPBIT]));
  endproperty
  a_mp_bit: assert property (p_mp_bit) else $error("mp bit not sent in parity slot");

  property p_lsb_first;
    @(posedge SYS_CLK) disable iff (!RST_B)
    (load && !s.fmt.sync) |=> (!TXD && s.sh[1] == $past(s.hold[0]));
  endproperty
  a_lsb_first: assert property (p_lsb_first) else $error("first data bit not lsb");

  property p_stop_high;
    @(posedge SYS_CLK) disable iff (!RST_B)
    (s_frame_end ##0 !s.fmt.sync) |-> TXD;
  endproperty
  a_stop_high: assert property (p_stop_high) else $error("last stop bit not high");

  property p_sync_bare;
    @(posedge SYS_CLK) disable iff (!RST_B)
    (load && s.fmt.sync) |=> (TXD == $past(s.hold[0]) && s.sh[11:8] == 4'hf);
  endproperty
  a_sync_bare: assert property (p_sync_bare) else $error("sync frame has framing");

  property p_seven;
    @(posedge SYS_CLK) disable iff (!RST_B)
    (load && !s.fmt.sync && s.fmt.chr && !s.fmt.pe && !s.fmt.mp)
      |=> (s.sh[7:1] == $past(s.hold[6:0]) && s.sh[8]);
  endproperty
  a_seven: assert property (p_seven) else $error("seven bit frame wrong");

  property p_par7;
    @(posedge SYS_CLK) disable iff (!RST_B)
    (load && !s.fmt.sync && s.fmt.pe && !s.fmt.mp && s.fmt.chr)
      |=> (s.sh[8] == (^s.sh[7:1] ^ $past(s.fmt.pm)));
  endproperty
  a_par7: assert property (p_par7) else $error("seven bit parity wrong");

  property p_two_stop;
    @(posedge SYS_CLK) disable iff (!RST_B)
    (load && !s.fmt.sync && s.fmt.stop2 && !s.fmt.pe && !s.fmt.mp && !s.fmt.chr)
      |=> (s.left == 4'hb && s.sh[10:9] == 2'b11);
  endproperty
  a_two_stop: assert property (p_two_stop) else $error("two stop bits missing");

  property p_prescale;
    @(posedge SYS_CLK) disable iff (!RST_B)
    (tick && s.fmt.cks != 2'b00) |=> !tick;
  endproperty
  a_prescale: assert property (p_prescale) else $error("prescaler ticked too often");

  property p_async_sck;
    @(posedge SYS_CLK) disable iff (!RST_B)
    (!s.fmt.sync && !$past(s.fmt.sync)) |-> SCK_OUT;
  endproperty
  a_async_sck: assert property (p_async_sck) else $error("bit clock moved in async mode");

  property p_reset_idle;
    @(posedge SYS_CLK)
    !RST_B |=> (TX_EMPTY && TXD && SCK_OUT);
  endproperty
  a_reset_idle: assert property (p_reset_idle) else $error("not idle after reset");
endmodule : stx_top

// ===== stx_partner.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module stx_partner (
  input  wire logic        clk,
  input  wire logic        txd,
  input  wire logic        sck,
  input  wire logic [3:0]  nb,
  output logic             rxd,
  output logic [11:0]      got,
  output logic [7:0]       sh,
  output int               cnt,
  output int               gap
);
  int cyc = 0;
  int last = 0;

  always @(posedge clk) cyc <= cyc + 1;

  // clocked mode: bit sampled on the rising bit clock
  always @(posedge sck) sh <= {txd, sh[7:1]};

  ////////////////////////////////////////////////////////////////////////////////
  // decoder assumes 16 clocks per bit, only valid at the fastest rate
  initial begin
    rxd = 1'b1;
    got = '0;
    cnt = 0;
    gap = 0;
    forever begin
      @(negedge txd);
      gap = cyc - last;
      last = cyc;
      repeat (8) @(posedge clk);
      for (int i = 0; i < 12; i++) begin
        got[i] = (i < nb) ? txd : 1'b0;
        if (i < nb - 1) repeat (16) @(posedge clk);
      end
      cnt = cnt + 1;
    end
  end

  // one stop bit, then straight into the next start if called again
  task automatic send(input logic [9:0] f);
    for (int i = 0; i < 10; i++) begin
      rxd <= f[i];
      repeat (16) @(posedge clk);
    end
  endtask : send
endmodule : stx_partner

// ===== stx_top_tb.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module stx_top_tb;
  logic        SYS_CLK;
  logic        RST_B;
  logic [2:0]  REG_ADDR;
  logic [7:0]  REG_WDATA;
  logic        REG_WR;
  logic        REG_RD;
  logic [7:0]  REG_RDATA;
  logic        RXD;
  logic        TXD;
  logic        SCK_OUT;
  logic        TX_EMPTY;
  logic [3:0]  nb;
  logic [11:0] got;
  logic [7:0]  sh;
  int          cnt;
  int          gap;
  int          n_fail = 0;
  int          compares = 0;
  int          n;
  int          len;
  logic [7:0]  r_fmt [7] = '{8'h00, 8'h40, 8'h20, 8'h30, 8'h08, 8'h24, 8'h60};
  logic [7:0]  r_dat [7] = '{8'ha5, 8'hc5, 8'h07, 8'h07, 8'h3c, 8'h03, 8'h81};
  logic [11:0] r_exp [7] = '{12'h34a, 12'h18a, 12'h60e, 12'h40e, 12'h678, 12'h606, 12'h302};
  logic [3:0]  r_nb  [7] = '{4'ha, 4'h9, 4'hb, 4'hb, 4'hb, 4'hb, 4'ha};

  stx_top stx_top_inst (
    .SYS_CLK   (SYS_CLK),
    .RST_B     (RST_B),
    .REG_ADDR  (REG_ADDR),
    .REG_WDATA (REG_WDATA),
    .REG_WR    (REG_WR),
    .REG_RD    (REG_RD),
    .REG_RDATA (REG_RDATA),
    .RXD       (RXD),
    .TXD       (TXD),
    .SCK_OUT   (SCK_OUT),
    .TX_EMPTY  (TX_EMPTY)
  );

  stx_partner stx_partner_inst (
    .clk (SYS_CLK),
    .txd (TXD),
    .sck (SCK_OUT),
    .nb  (nb),
    .rxd (RXD),
    .got (got),
    .sh  (sh),
    .cnt (cnt),
    .gap (gap)
  );

  initial begin
    SYS_CLK = 1'b0;
    forever #12.5 SYS_CLK = ~SYS_CLK;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %0t seen %h want %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge SYS_CLK);
    REG_ADDR <= a;
    REG_WDATA <= d;
    REG_WR <= 1'b1;
    @(posedge SYS_CLK);
    REG_WR <= 1'b0;
  endtask : wr

  task automatic rdc(input logic [2:0] a, input logic [7:0] e);
    @(posedge SYS_CLK);
    REG_ADDR <= a;
    REG_RD <= 1'b1;
    @(posedge SYS_CLK);
    REG_RD <= 1'b0;
    @(negedge SYS_CLK);
    chk({4'h0, REG_RDATA}, {4'h0, e});
  endtask : rdc

  // software side waits for the empty flag before each byte
  task automatic send_byte(input logic [7:0] d);
    // look at the flag only once the edge's updates have settled
    @(negedge SYS_CLK);
    for (int k = 0; k < 5000 && TX_EMPTY !== 1'b1; k++) @(negedge SYS_CLK);
    wr(3'h0, d);
  endtask : send_byte

  task automatic wait_frame(input int m);
    for (int k = 0; k < 20000 && cnt < m; k++) @(posedge SYS_CLK);
    chk({11'h0, cnt >= m}, 12'h1);
    repeat (24) @(posedge SYS_CLK);
  endtask : wait_frame

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : wrap_up

  initial begin
    repeat (60000) @(posedge SYS_CLK);
    n_fail++;
    wrap_up();
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    RST_B = 1'b0;
    REG_WR = 1'b0;
    REG_RD = 1'b0;
    REG_ADDR = 3'h0;
    REG_WDATA = 8'h00;
    nb = 4'ha;
    repeat (8) @(posedge SYS_CLK);
    RST_B <= 1'b1;
    rdc(3'h0, 8'hff);
    rdc(3'h1, 8'h00);
    wr(3'h4, 8'h31);
    // divisor 0: one tick per clock, the rate the partner decoder assumes
    wr(3'h3, 8'h00);
    for (int i = 0; i < 7; i++) begin
      wr(3'h1, r_fmt[i]);
      nb = r_nb[i];
      n = cnt + 1;
      send_byte(r_dat[i]);
      wait_frame(n);
      chk(got, r_exp[i]);
    end
    // second byte queued during a frame must follow with no idle gap
    wr(3'h1, 8'h00);
    nb = 4'ha;
    n = cnt + 2;
    send_byte(8'ha1);
    send_byte(8'hb2);
    wait_frame(n);
    chk(got, 12'h364);
    chk(gap[11:0], 12'd160);
    // data bit length per prescaler code, alternating bits avoid start phase
    for (int c = 0; c < 4; c++) begin
      wr(3'h1, {6'h00, c[1:0]});
      send_byte(8'h55);
      len = 0;
      for (int k = 0; k < 3000 && TXD !== 1'b0; k++) @(posedge SYS_CLK);
      for (int k = 0; k < 3000 && TXD === 1'b0; k++) @(posedge SYS_CLK);
      for (int k = 0; k < 3000 && TXD === 1'b1; k++) begin
        @(posedge SYS_CLK);
        len++;
      end
      chk(len[11:0], 12'd16 << (2 * c));
      repeat (12 * (16 << (2 * c))) @(posedge SYS_CLK);
    end
    wr(3'h1, 8'hf8);
    send_byte(8'h96);
    repeat (300) @(posedge SYS_CLK);
    chk({4'h0, sh}, 12'h096);
    wr(3'h1, 8'h08);
    stx_partner_inst.send(10'h2b4);
    stx_partner_inst.send(10'h386);
    repeat (40) @(posedge SYS_CLK);
    rdc(3'h5, 8'hc3);
    @(posedge SYS_CLK);
    RST_B <= 1'b0;
    repeat (2) @(posedge SYS_CLK);
    RST_B <= 1'b1;
    rdc(3'h1, 8'h00);
    rdc(3'h0, 8'hff);
    rdc(3'h2, 8'h84);
    chk({11'h0, TX_EMPTY}, 12'h001);
    wrap_up();
  end
endmodule : stx_top_tb
